/* dv/data_memory_map_decoder_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module data_memory_map_decoder_tb;
  logic sys_clk, rstn, clk_en, rst_sys, rst_cold, rst_pconf, rst_sleep, imem_wr;
  logic [12:0] imem_addr;
  logic [21:0] imem_wdata, imem_rdata;
  logic [15:0] dmem_addr;
  logic dmem_rd, dmem_wr, dmem_rvalid, acq_sel, vld_sel, per_wr, per_rd;
  logic [7:0] dmem_wdata, dmem_rdata, per_wdata, acq_rdata, vld_rdata;
  logic [7:0] sys_flag_set, sys_ctrl, sys_clock;
  logic [2:0] per_addr;
  logic [7:0] cyc = 8'h00;
  int n_mismatch = 0;
  int total_checks = 0;

  // clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // peripherals answer only while selected for a read, else a moving pattern
  always @(posedge sys_clk) cyc <= cyc + 8'h01;
  assign acq_rdata = (acq_sel && per_rd) ? {5'h15, per_addr} : cyc;
  assign vld_rdata = (vld_sel && per_rd) ? {5'h0c, per_addr} : ~cyc;

  dmmd_core_model core_u (.sys_clk(sys_clk), .dmem_addr(dmem_addr), .dmem_rd(dmem_rd),
    .dmem_wr(dmem_wr), .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata),
    .dmem_rvalid(dmem_rvalid));

  dmmd_decoder dut_u (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .rst_sys(rst_sys),
    .rst_cold(rst_cold), .rst_pconf(rst_pconf), .rst_sleep(rst_sleep),
    .imem_addr(imem_addr), .imem_wr(imem_wr), .imem_wdata(imem_wdata),
    .imem_rdata(imem_rdata), .dmem_addr(dmem_addr), .dmem_rd(dmem_rd), .dmem_wr(dmem_wr),
    .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata), .dmem_rvalid(dmem_rvalid),
    .acq_sel(acq_sel), .vld_sel(vld_sel), .per_addr(per_addr), .per_wr(per_wr),
    .per_rd(per_rd), .per_wdata(per_wdata), .acq_rdata(acq_rdata), .vld_rdata(vld_rdata),
    .sys_flag_set(sys_flag_set), .sys_ctrl(sys_ctrl), .sys_clock(sys_clock));

  // one compare for every kind of value, flags zero-extended
  task automatic chk(input logic [21:0] got, input logic [21:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // read through the core, compare masked data and the valid pulse
  task automatic rdc(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    core_u.rd_byte(a, d, ok);
    chk({14'h0, d & m}, {14'h0, e});
    chk({21'h0, ok}, 22'h1);
  endtask

  task automatic t_reset();
    rdc(16'h0010, 8'hff, 8'h00);
    rdc(16'h0011, 8'hff, 8'h00);
    rdc(16'h0012, 8'hff, 8'h1d);
    chk({14'h0, sys_clock}, 22'h1d);
    $display("test reset done");
  endtask

  // lower bank and both ends of ram, read back after all writes to catch aliasing
  task automatic t_map();
    for (int i = 0; i < 8; i++) core_u.wr_byte(16'(i), 8'h5a ^ 8'(i));
    core_u.wr_byte(16'h0080, 8'hc3);
    core_u.wr_byte(16'h027f, 8'h3c);
    core_u.wr_byte(16'h0015, 8'hff);
    for (int i = 0; i < 8; i++) rdc(16'(i), 8'hff, 8'h5a ^ 8'(i));
    rdc(16'h0080, 8'hff, 8'hc3);
    rdc(16'h027f, 8'hff, 8'h3c);
    rdc(16'h0008, 8'hff, 8'h00);
    rdc(16'h0015, 8'hff, 8'h00);
    $display("test map done");
  endtask

  task automatic t_const();
    core_u.wr_byte(16'h0010, 8'hff);
    rdc(16'h0010, 8'hff, 8'hf0);
    chk({14'h0, sys_ctrl}, 22'hf0);
    core_u.wr_byte(16'h0012, 8'h00);
    rdc(16'h0012, 8'h08, 8'h08);
    // a write while the enable is low must leave every register as it was
    @(negedge sys_clk) clk_en = 1'b0;
    core_u.wr_byte(16'h0010, 8'h00);
    clk_en = 1'b1;
    chk({14'h0, sys_ctrl}, 22'hf0);
    $display("test const done");
  endtask

  // only the bits of the pulsed domain may reload
  task automatic t_domains();
    @(negedge sys_clk) rst_pconf = 1'b1;
    @(negedge sys_clk) rst_pconf = 1'b0;
    chk({14'h0, sys_ctrl}, 22'hf0);
    @(negedge sys_clk) rst_sleep = 1'b1;
    @(negedge sys_clk) rst_sleep = 1'b0;
    chk({14'h0, sys_ctrl}, 22'hf0);
    chk({14'h0, sys_clock}, 22'h0d);
    @(negedge sys_clk) rst_cold = 1'b1;
    @(negedge sys_clk) rst_cold = 1'b0;
    chk({14'h0, sys_ctrl}, 22'h00);
    chk({14'h0, sys_clock}, 22'h1d);
    $display("test domains done");
  endtask

  task automatic t_flags();
    @(negedge sys_clk) sys_flag_set = 8'hff;
    @(negedge sys_clk) sys_flag_set = 8'h00;
    rdc(16'h0011, 8'hff, 8'h7f);
    rdc(16'h0011, 8'hff, 8'h41);
    core_u.wr_byte(16'h0011, 8'h00);
    rdc(16'h0011, 8'hff, 8'h40);
    core_u.wr_byte(16'h0011, 8'h40);
    rdc(16'h0011, 8'hff, 8'h00);
    core_u.wr_byte(16'h0011, 8'h80);
    rdc(16'h0011, 8'hff, 8'h80);
    @(negedge sys_clk) rst_sys = 1'b1;
    @(negedge sys_clk) rst_sys = 1'b0;
    rdc(16'h0011, 8'hff, 8'h00);
    // hardware set and a clearing write in one cycle: the set wins
    fork
      core_u.wr_byte(16'h0011, 8'h40);
      begin
        @(negedge sys_clk) sys_flag_set = 8'h40;
        @(negedge sys_clk) sys_flag_set = 8'h00;
      end
    join
    rdc(16'h0011, 8'hff, 8'h40);
    core_u.wr_byte(16'h0011, 8'h40);
    rdc(16'h0011, 8'hff, 8'h00);
    $display("test flags done");
  endtask

  task automatic t_window();
    for (int i = 0; i < 8; i++) begin
      rdc(16'h0060 + 16'(i), 8'hff, 8'ha8 | 8'(i));
      chk({20'h0, acq_sel, vld_sel}, 22'h2);
    end
    rdc(16'h007e, 8'hff, 8'h66);
    chk({20'h0, acq_sel, vld_sel}, 22'h1);
    rdc(16'h007f, 8'hff, 8'h67);
    rdc(16'h001f, 8'hff, 8'h00);
    chk({20'h0, acq_sel, vld_sel}, 22'h0);
    core_u.wr_byte(16'h0063, 8'h96);
    chk({8'h0, acq_sel, per_wr, per_rd, per_addr, per_wdata}, {8'h0, 3'b110, 3'h3, 8'h96});
    $display("test window done");
  endtask

  // instruction fetch runs in the same cycle as a data read
  task automatic t_imem();
    @(negedge sys_clk);
    imem_addr = 13'h0000;
    imem_wdata = 22'h2a5a5a;
    imem_wr = 1'b1;
    @(negedge sys_clk);
    imem_addr = 13'h1fff;
    imem_wdata = 22'h15a5a5;
    @(negedge sys_clk) imem_wr = 1'b0;
    fork
      rdc(16'h0001, 8'hff, 8'h5b);
      begin
        @(negedge sys_clk) imem_addr = 13'h0000;
        @(negedge sys_clk) chk(imem_rdata, 22'h2a5a5a);
      end
    join
    @(negedge sys_clk) imem_addr = 13'h1fff;
    @(negedge sys_clk) chk(imem_rdata, 22'h15a5a5);
    $display("test imem done");
  endtask

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_mismatch++;
    end_of_test();
  end

  // main sequence
  initial begin
    rstn = 1'b0;
    {rst_sys, rst_cold, rst_pconf, rst_sleep, imem_wr} = 5'h00;
    clk_en = 1'b1;
    imem_addr = 13'h0000;
    imem_wdata = 22'h000000;
    sys_flag_set = 8'h00;
    repeat (4) @(negedge sys_clk);
    rstn = 1'b1;
    t_reset();
    t_map();
    t_const();
    t_domains();
    t_flags();
    t_window();
    t_imem();
    end_of_test();
  end
endmodule
`default_nettype wire

/* dv/dmmd_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
// behavioural core: one data access per cycle, qualifiers move only at the falling edge
module dmmd_core_model (
  // clock
  input wire logic sys_clk,
  // data bus
  output logic [15:0] dmem_addr,
  output logic dmem_rd,
  output logic dmem_wr,
  output logic [7:0] dmem_wdata,
  input wire logic [7:0] dmem_rdata,
  input wire logic dmem_rvalid
);
  // idle bus at time zero
  initial begin
    dmem_addr = 16'h0000;
    dmem_rd = 1'b0;
    dmem_wr = 1'b0;
    dmem_wdata = 8'h00;
  end

  // write is taken at the rising edge between the two falling edges
  task automatic wr_byte(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    dmem_addr = a;
    dmem_wdata = d;
    dmem_wr = 1'b1;
    @(negedge sys_clk);
    dmem_wr = 1'b0;
    dmem_wdata = ~d; // released data must not look like the last byte
  endtask

  // answer stands one cycle only, so it is sampled in that cycle
  task automatic rd_byte(input logic [15:0] a, output logic [7:0] d, output logic ok);
    @(negedge sys_clk);
    dmem_addr = a;
    dmem_rd = 1'b1;
    @(negedge sys_clk);
    dmem_rd = 1'b0;
    d = dmem_rdata;
    ok = dmem_rvalid;
  endtask
endmodule
`default_nettype wire

/* verilog/dmmd_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - instruction and data memories are separate, each with its own bus.
// - instruction fetch proceeds in the same cycle as a data access.
// - instruction store holds 8192 words of 22 bits.
// - data space has 8 low-power registers, two peripheral windows and 512 RAM bytes.
// - addresses 0000-0007 go to the low-power register bank.
// - addresses 0010-001f go to system, clock and reset registers.
// - addresses 0060-0067 go to the acquisition-chain window.
// - addresses 007e-007f go to the supply-level detector.
// - clear-on-any-write bits become zero on any write to their register.
// - write-one-to-clear bits clear only where a one is written.
// - clear-on-read bits return their value then clear.
// - each system-register bit belongs to one of four reset domains and loads its initial value.
module dmmd_decoder (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // reset domain requests, active high, synchronous
  input wire logic rst_sys,
  input wire logic rst_cold,
  input wire logic rst_pconf,
  input wire logic rst_sleep,
  // instruction bus
  input wire logic [12:0] imem_addr,
  input wire logic imem_wr,
  input wire logic [21:0] imem_wdata,
  output logic [21:0] imem_rdata,
  // data bus
  input wire logic [15:0] dmem_addr,
  input wire logic dmem_rd,
  input wire logic dmem_wr,
  input wire logic [7:0] dmem_wdata,
  output logic [7:0] dmem_rdata,
  output logic dmem_rvalid,
  // peripheral windows
  output logic acq_sel,
  output logic vld_sel,
  output logic [2:0] per_addr,
  output logic per_wr,
  output logic per_rd,
  output logic [7:0] per_wdata,
  input wire logic [7:0] acq_rdata,
  input wire logic [7:0] vld_rdata,
  // hardware event inputs setting system flag bits
  input wire logic [7:0] sys_flag_set,
  // system register contents
  output logic [7:0] sys_ctrl,
  output logic [7:0] sys_clock
);
  // separate arrays and buses for code and data
  logic [21:0] imem [0:8191];
  logic [7:0] dram [0:511];
  logic [7:0] lpr [0:7];
  logic [7:0] ctrl;
  logic [7:0] flags;
  logic [7:0] clk_reg;
  dmmd_pkg::dmmd_reg_e region;
  dmmd_pkg::dmmd_reg_e rd_region;
  logic [7:0] rd_local;
  logic [7:0] next_rd_local;
  logic [7:0] wr_en;
  logic [8:0] ram_idx;

  // per-bit access code tables for the system registers
  function automatic dmmd_pkg::dmmd_acc_e acc_of(input logic [3:0] idx, input int b);
    acc_of = dmmd_pkg::constant_zero_code;
    case (idx)
      dmmd_pkg::SYS_CTRL: acc_of = (b >= 4) ? dmmd_pkg::dmmd_rw : dmmd_pkg::constant_zero_code;
      dmmd_pkg::SYS_FLAGS: begin
        if (b == 7) acc_of = dmmd_pkg::dmmd_rw;
        else if (b == 6) acc_of = dmmd_pkg::write_one_to_clear_code;
        else if (b == 0) acc_of = dmmd_pkg::clear_any_write_code;
        else acc_of = dmmd_pkg::clear_on_read_code;
      end
      dmmd_pkg::SYS_CLOCK: acc_of = (b == 3) ? dmmd_pkg::constant_one_code : dmmd_pkg::dmmd_rw;
      default: acc_of = dmmd_pkg::constant_zero_code;
    endcase
  endfunction

  // reset domain of each system-register bit
  function automatic logic dom_hit(input logic [3:0] idx, input int b);
    dmmd_pkg::dmmd_dom_e d;
    d = dmmd_pkg::dmmd_cold;
    if (idx == dmmd_pkg::SYS_FLAGS && b == 7) d = dmmd_pkg::dmmd_sys;
    if (idx == dmmd_pkg::SYS_CLOCK && (b == 7 || b <= 3)) d = dmmd_pkg::dmmd_sleep;
    case (d)
      dmmd_pkg::dmmd_sys: dom_hit = rst_sys;
      dmmd_pkg::dmmd_cold: dom_hit = rst_cold;
      dmmd_pkg::dmmd_pconf: dom_hit = rst_pconf;
      dmmd_pkg::dmmd_sleep: dom_hit = rst_sleep;
      default: dom_hit = 1'b0;
    endcase
  endfunction

  // address decode
  always_comb begin
    region = dmmd_pkg::dmmd_none;
    if (dmem_addr <= dmmd_pkg::LPR_HI) region = dmmd_pkg::dmmd_lpr;
    else if (dmem_addr >= dmmd_pkg::SYS_LO && dmem_addr <= dmmd_pkg::SYS_HI)
      region = dmmd_pkg::dmmd_sysr;
    else if (dmem_addr >= dmmd_pkg::ACQ_LO && dmem_addr <= dmmd_pkg::ACQ_HI)
      region = dmmd_pkg::dmmd_acq;
    else if (dmem_addr >= dmmd_pkg::VLD_LO && dmem_addr <= dmmd_pkg::VLD_HI)
      region = dmmd_pkg::dmmd_vld;
    else if (dmem_addr >= dmmd_pkg::RAM_LO && dmem_addr <= dmmd_pkg::RAM_HI)
      region = dmmd_pkg::dmmd_ram;
  end

  assign ram_idx = 9'(dmem_addr - dmmd_pkg::RAM_LO);

  // fetch runs every cycle that clk_en is high, independent of the data port
  always_ff @(posedge sys_clk) begin
    if (clk_en) begin
      if (imem_wr) imem[imem_addr] <= imem_wdata;
      imem_rdata <= imem[imem_addr];
    end
  end

  // ram and low-power bank: plain storage, undefined at power up
  always_ff @(posedge sys_clk) begin
    if (clk_en && dmem_wr && region == dmmd_pkg::dmmd_ram) dram[ram_idx] <= dmem_wdata;
    if (clk_en && dmem_wr && region == dmmd_pkg::dmmd_lpr) lpr[dmem_addr[2:0]] <= dmem_wdata;
  end

  // local read mux; unmapped register space reads zero
  always_comb begin
    next_rd_local = 8'h00;
    case (region)
      dmmd_pkg::dmmd_lpr: next_rd_local = lpr[dmem_addr[2:0]];
      dmmd_pkg::dmmd_ram: next_rd_local = dram[ram_idx];
      dmmd_pkg::dmmd_sysr: begin
        for (int b = 0; b < 8; b++) begin
          case (acc_of(dmem_addr[3:0], b))
            dmmd_pkg::constant_one_code: next_rd_local[b] = 1'b1;
            dmmd_pkg::constant_zero_code: next_rd_local[b] = 1'b0;
            default: begin
              case (dmem_addr[3:0])
                dmmd_pkg::SYS_CTRL: next_rd_local[b] = ctrl[b];
                dmmd_pkg::SYS_FLAGS: next_rd_local[b] = flags[b];
                dmmd_pkg::SYS_CLOCK: next_rd_local[b] = clk_reg[b];
                default: next_rd_local[b] = 1'b0;
              endcase
            end
          endcase
        end
      end
      default: next_rd_local = 8'h00;
    endcase
  end

  // read answers one cycle after the strobe; one access per cycle assumed
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dmem_rvalid <= 1'b0;
      rd_local <= 8'h00;
      rd_region <= dmmd_pkg::dmmd_none;
    end else if (clk_en) begin
      dmem_rvalid <= dmem_rd && !dmem_wr;
      rd_local <= next_rd_local;
      rd_region <= region;
    end
  end

  // peripherals answer on the cycle after their strobe, so mux late
  always_comb begin
    case (rd_region)
      dmmd_pkg::dmmd_acq: dmem_rdata = acq_rdata;
      dmmd_pkg::dmmd_vld: dmem_rdata = vld_rdata;
      default: dmem_rdata = rd_local;
    endcase
  end

  // peripheral window strobes, registered
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      acq_sel <= 1'b0;
      vld_sel <= 1'b0;
      per_addr <= 3'h0;
      per_wr <= 1'b0;
      per_rd <= 1'b0;
      per_wdata <= 8'h00;
    end else if (clk_en) begin
      acq_sel <= region == dmmd_pkg::dmmd_acq;
      vld_sel <= region == dmmd_pkg::dmmd_vld;
      per_addr <= dmem_addr[2:0];
      per_wr <= dmem_wr;
      per_rd <= dmem_rd;
      per_wdata <= dmem_wdata;
    end
  end

  assign wr_en = {8{dmem_wr && region == dmmd_pkg::dmmd_sysr}};

  // system registers: per-bit access semantics and reset domains
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= dmmd_pkg::CTRL_RST;
      flags <= dmmd_pkg::FLAGS_RST;
      clk_reg <= dmmd_pkg::CLOCK_RST;
    end else if (clk_en) begin
      for (int b = 0; b < 8; b++) begin
        if (dom_hit(dmmd_pkg::SYS_CTRL, b)) ctrl[b] <= dmmd_pkg::CTRL_RST[b];
        else if (wr_en[b] && dmem_addr[3:0] == dmmd_pkg::SYS_CTRL &&
                 acc_of(dmmd_pkg::SYS_CTRL, b) == dmmd_pkg::dmmd_rw)
          ctrl[b] <= dmem_wdata[b];
        if (dom_hit(dmmd_pkg::SYS_CLOCK, b)) clk_reg[b] <= dmmd_pkg::CLOCK_RST[b];
        else if (wr_en[b] && dmem_addr[3:0] == dmmd_pkg::SYS_CLOCK &&
                 acc_of(dmmd_pkg::SYS_CLOCK, b) == dmmd_pkg::dmmd_rw)
          clk_reg[b] <= dmem_wdata[b];
        // hardware set wins over any clearing access in the same cycle; a reset domain reload wins over the set
        if (dom_hit(dmmd_pkg::SYS_FLAGS, b)) flags[b] <= dmmd_pkg::FLAGS_RST[b];
        else if (sys_flag_set[b] && b != 7) flags[b] <= 1'b1;
        else if (dem_flags(b)) flags[b] <= 1'b0;
        else if (b == 7 && wr_en[b] && dmem_addr[3:0] == dmmd_pkg::SYS_FLAGS)
          flags[b] <= dmem_wdata[b];
      end
    end
  end

  // clear condition for one flag bit under its access code
  function automatic logic dem_flags(input int b);
    logic hit;
    hit = region == dmmd_pkg::dmmd_sysr && dmem_addr[3:0] == dmmd_pkg::SYS_FLAGS;
    case (acc_of(dmmd_pkg::SYS_FLAGS, b))
      dmmd_pkg::clear_any_write_code: dem_flags = hit && dmem_wr;
      dmmd_pkg::write_one_to_clear_code: dem_flags = hit && dmem_wr && dmem_wdata[b];
      dmmd_pkg::clear_on_read_code: dem_flags = hit && dmem_rd && !dmem_wr;
      default: dem_flags = 1'b0;
    endcase
  endfunction

  assign sys_ctrl = ctrl;
  assign sys_clock = clk_reg;

  // assertions
  sequence flag_read_s;
    dmem_rd && !dmem_wr && region == dmmd_pkg::dmmd_sysr &&
      dmem_addr[3:0] == dmmd_pkg::SYS_FLAGS && !rst_cold && clk_en;
  endsequence

  clear_on_read_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    flag_read_s and sys_flag_set[1] == 1'b0 |=> flags[1] == 1'b0 && dmem_rvalid)
    else $error("clear-on-read bit survived a read");
  w1c_zero_keep_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    clk_en && dmem_wr && region == dmmd_pkg::dmmd_sysr && dmem_addr[3:0] == dmmd_pkg::SYS_FLAGS
    && !dmem_wdata[6] && !rst_cold |=> flags[6] == $past(flags[6]) || $past(sys_flag_set[6]))
    else $error("write of zero changed a write-one-to-clear bit");
  w1c_one_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    clk_en && dmem_wr && region == dmmd_pkg::dmmd_sysr && dmem_addr[3:0] == dmmd_pkg::SYS_FLAGS
    && dmem_wdata[6] && !sys_flag_set[6] |=> !flags[6])
    else $error("write of one left bit set");
  any_write_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    clk_en && dmem_wr && region == dmmd_pkg::dmmd_sysr && dmem_addr[3:0] == dmmd_pkg::SYS_FLAGS
    && !sys_flag_set[0] |=> !flags[0])
    else $error("clear-on-write bit survived a write");
  cold_reset_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    clk_en && rst_cold |=> ctrl == dmmd_pkg::CTRL_RST)
    else $error("cold domain did not reload");
  sleep_reset_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    clk_en && rst_sleep |=> clk_reg[1:0] == dmmd_pkg::CLOCK_RST[1:0])
    else $error("sleep domain did not reload");
  const_bits_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    clk_en && dmem_rd && region == dmmd_pkg::dmmd_sysr && dmem_addr[3:0] == dmmd_pkg::SYS_CTRL
    |=> dmem_rdata[3:0] == 4'h0)
    else $error("constant-zero bits read nonzero");
  acq_route_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    clk_en && dmem_addr >= dmmd_pkg::ACQ_LO && dmem_addr <= dmmd_pkg::ACQ_HI |=> acq_sel && !vld_sel)
    else $error("acquisition window not selected");
  vld_route_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    clk_en && dmem_addr >= dmmd_pkg::VLD_LO && dmem_addr <= dmmd_pkg::VLD_HI |=> vld_sel && !acq_sel)
    else $error("detector window not selected");
  unmapped_zero_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    clk_en && dmem_rd && region == dmmd_pkg::dmmd_none |=> dmem_rdata == 8'h00)
    else $error("unmapped address read nonzero");
endmodule
`default_nettype wire

/* verilog/dmmd_pkg.sv */
package dmmd_pkg;
  // data address map
  localparam logic [15:0] LPR_LO = 16'h0000;
  localparam logic [15:0] LPR_HI = 16'h0007;
  localparam logic [15:0] SYS_LO = 16'h0010;
  localparam logic [15:0] SYS_HI = 16'h001f;
  localparam logic [15:0] ACQ_LO = 16'h0060;
  localparam logic [15:0] ACQ_HI = 16'h0067;
  localparam logic [15:0] VLD_LO = 16'h007e;
  localparam logic [15:0] VLD_HI = 16'h007f;
  localparam logic [15:0] RAM_LO = 16'h0080;
  localparam logic [15:0] RAM_HI = 16'h027f;
  // sizes
  localparam int LPR_N = 8;
  localparam int RAM_N = 512;
  localparam int IMEM_N = 8192;
  localparam int IW = 22;
  localparam int IAW = 13;
  localparam int RAW = 9;
  // system-space register indices (low nibble of address)
  localparam logic [3:0] SYS_CTRL = 4'h0;
  localparam logic [3:0] SYS_FLAGS = 4'h1;
  localparam logic [3:0] SYS_CLOCK = 4'h2;
  // per-bit access codes
  typedef enum logic [2:0] {
    dmmd_rw = 3'b000,
    constant_zero_code = 3'b001,
    constant_one_code = 3'b010,
    clear_any_write_code = 3'b011,
    write_one_to_clear_code = 3'b100,
    clear_on_read_code = 3'b101
  } dmmd_acc_e;
  // reset domains
  typedef enum logic [1:0] {
    dmmd_sys = 2'b00,
    dmmd_cold = 2'b01,
    dmmd_pconf = 2'b10,
    dmmd_sleep = 2'b11
  } dmmd_dom_e;
  // region select
  typedef enum logic [2:0] {
    dmmd_none = 3'b000,
    dmmd_lpr = 3'b001,
    dmmd_sysr = 3'b010,
    dmmd_acq = 3'b011,
    dmmd_vld = 3'b100,
    dmmd_ram = 3'b101
  } dmmd_reg_e;
  // reset values of the three system registers
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] CLOCK_RST = 8'h1d;
endpackage
